// ### rtl/fpts_defs.svh
`ifndef FPTS_DEFS_SVH
`define FPTS_DEFS_SVH

// status word fields
`define FPTS_SW_BUSY_COPY    15
`define FPTS_SW_COND3        14
`define FPTS_SW_TOP_HI       13
`define FPTS_SW_TOP_LO       11
`define FPTS_SW_COND_HI      10
`define FPTS_SW_COND_LO      8
`define FPTS_SW_ERR_SUM      7
`define FPTS_SW_STACK_FAULT  6
`define FPTS_SW_EXC_HI       5

// control word fields
`define FPTS_CW_RND_HI       11
`define FPTS_CW_RND_LO       10
`define FPTS_CW_PREC_HI      9
`define FPTS_CW_PREC_LO      8
`define FPTS_CW_MASK_HI      5
`define FPTS_CW_WRITABLE     16'h0F3F

// reset values
`define FPTS_TAGS_RESET      16'hFFFF
`define FPTS_STATUS_RESET    16'h0000
`define FPTS_CONTROL_RESET   16'h0000

// environment image word indices
`define FPTS_ENV_CONTROL     3'h0
`define FPTS_ENV_STATUS      3'h1
`define FPTS_ENV_TAGS        3'h2
`define FPTS_ENV_IP_LO       3'h3
`define FPTS_ENV_IP_HI       3'h4
`define FPTS_ENV_OP_LO       3'h5
`define FPTS_ENV_OP_HI       3'h6

`endif

// ### rtl/fpts_pkg.sv
package fpts_pkg;
    typedef enum logic [1:0] {
        FPTS_TAG_VALID   = 2'h0,
        FPTS_TAG_ZERO    = 2'h1,
        FPTS_TAG_SPECIAL = 2'h2,
        FPTS_TAG_EMPTY   = 2'h3
    } fpts_tag_t;

    typedef enum logic [1:0] {
        FPTS_RND_NEAREST = 2'h0,
        FPTS_RND_DOWN    = 2'h1,
        FPTS_RND_UP      = 2'h2,
        FPTS_RND_TRUNC   = 2'h3
    } fpts_round_t;

    typedef enum logic [1:0] {
        FPTS_PREC_24  = 2'h0,
        FPTS_PREC_RSV = 2'h1,
        FPTS_PREC_53  = 2'h2,
        FPTS_PREC_64  = 2'h3
    } fpts_prec_t;

    // value class reported by the execution side for a written register
    typedef enum logic [2:0] {
        FPTS_CLS_NORMAL    = 3'h0,
        FPTS_CLS_ZERO      = 3'h1,
        FPTS_CLS_DENORMAL  = 3'h2,
        FPTS_CLS_INFINITY  = 3'h3,
        FPTS_CLS_QNAN      = 3'h4,
        FPTS_CLS_SNAN      = 3'h5,
        FPTS_CLS_UNSUPPORT = 3'h6
    } fpts_class_t;

    typedef enum logic [1:0] {
        FPTS_ST_IDLE  = 2'b00,
        FPTS_ST_STORE = 2'b01,
        FPTS_ST_DONE  = 2'b11
    } fpts_state_t;
endpackage : fpts_pkg

// ### rtl/fpts_tag_slot.sv
`include "fpts_defs.svh"

module fpts_tag_slot
    import fpts_pkg::*;
(
    // clock and reset
    input  wire logic      core_clk,
    input  wire logic      rst,
    // updates
    input  wire logic      init,
    input  wire logic      load,
    input  wire logic [1:0] load_val,
    input  wire logic      wr,
    input  wire fpts_class_t wr_class,
    input  wire logic      free,
    // state
    output logic [1:0]     tag
);
    logic [1:0] tag_reg;
    logic [1:0] tag_next;
    logic [1:0] class_tag;

    // every non-finite or odd format collapses to special
    assign class_tag = (wr_class == FPTS_CLS_NORMAL) ? FPTS_TAG_VALID :
                       (wr_class == FPTS_CLS_ZERO)   ? FPTS_TAG_ZERO  :
                                                       FPTS_TAG_SPECIAL;

    assign tag_next = init ? FPTS_TAG_EMPTY :
                      load ? load_val :
                      wr   ? class_tag :
                      free ? FPTS_TAG_EMPTY : tag_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) tag_reg <= 2'h3;
        else     tag_reg <= tag_next;
    end

    assign tag = tag_reg;
endmodule : fpts_tag_slot

// ### rtl/fpts_regs.sv
`include "fpts_defs.svh"

module fpts_regs
    import fpts_pkg::*;
#(
    parameter int NREGS = 8,
    parameter int DW    = 80,
    parameter int AW    = 32
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // initialization request from the core
    input  wire logic              fp_init,
    // execution results
    input  wire logic              res_wr,
    input  wire logic [2:0]        res_phys,
    input  wire logic [DW-1:0]     res_data,
    input  wire fpts_class_t       res_class,
    input  wire logic              stk_push,
    input  wire logic              stk_pop,
    input  wire logic              free_wr,
    input  wire logic [2:0]        free_phys,
    input  wire logic              cond_wr,
    input  wire logic [3:0]        cond_val,
    input  wire logic [5:0]        exc_raise,
    input  wire logic              stack_fault_raise,
    input  wire logic              clear_exc,
    input  wire logic              ptr_wr,
    input  wire logic [AW-1:0]     instr_ptr_in,
    input  wire logic [AW-1:0]     operand_ptr_in,
    // data register read port
    input  wire logic [2:0]        rd_phys,
    output logic [DW-1:0]          rd_data,
    // environment store/restore port
    input  wire logic              env_store_op,
    input  wire logic              full_state_save_op,
    input  wire logic              env_restore_op,
    input  wire logic [15:0]       env_control_in,
    input  wire logic [15:0]       env_status_in,
    input  wire logic [15:0]       env_tags_in,
    output logic                   env_valid,
    output logic [2:0]             env_index,
    output logic [15:0]            env_word,
    output logic                   env_busy,
    // status, always visible
    output logic [15:0]            fpu_status_word,
    // mode outputs to the execution unit
    output fpts_round_t            rounding_select,
    output fpts_prec_t             precision_select,
    output logic                   trap_req
);
    // storage
    logic [DW-1:0] data_reg [NREGS];
    logic [AW-1:0] instr_ptr_reg;
    logic [AW-1:0] operand_ptr_reg;
    logic [15:0]   control_reg;
    logic [2:0]    stack_top_index_reg;
    logic [3:0]    cond_reg;
    logic          error_summary_reg;
    logic          stack_fault_flag_reg;
    logic [5:0]    exc_reg;
    fpts_state_t   state_reg;
    fpts_state_t   state_next;
    logic [2:0]    idx_reg;
    logic [2:0]    idx_next;
    logic          env_valid_reg;
    logic [15:0]   env_word_reg;
    logic [15:0]   env_word_next;
    logic [2:0]    env_index_reg;

    // decode wires
    logic [15:0]   fpu_register_tags;
    logic [15:0]   status_next_w;
    logic [15:0]   control_next;
    logic [2:0]    top_next;
    logic [3:0]    cond_next;
    logic [5:0]    exc_next;
    logic [5:0]    exc_unmasked;
    logic          error_summary_next;
    logic          stack_fault_next;
    logic          do_restore;
    logic          start_store;
    logic [5:0]    exc_mask;

    assign do_restore  = env_restore_op && (state_reg == FPTS_ST_IDLE);
    assign start_store = (env_store_op || full_state_save_op) && (state_reg == FPTS_ST_IDLE);

    // data registers and tags per physical slot
    genvar g;
    generate
        for (g = 0; g < NREGS; g++) begin : g_slot
            logic hit_wr;
            logic hit_free;
            assign hit_wr   = res_wr && (res_phys == 3'(g));
            assign hit_free = free_wr && (free_phys == 3'(g));

            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) data_reg[g] <= '0;
                else if (hit_wr) data_reg[g] <= res_data;
            end

            fpts_tag_slot u_tag (
                .core_clk (core_clk),
                .rst      (rst),
                .init     (fp_init),
                .load     (do_restore),
                .load_val (env_tags_in[2*g +: 2]),
                .wr       (hit_wr),
                .wr_class (res_class),
                .free     (hit_free),
                .tag      (fpu_register_tags[2*g +: 2])
            );
        end
    endgenerate

    assign rd_data = data_reg[rd_phys];

    // pointer registers capture the instruction and operand locations
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            instr_ptr_reg   <= '0;
            operand_ptr_reg <= '0;
        end else if (ptr_wr) begin
            instr_ptr_reg   <= instr_ptr_in;
            operand_ptr_reg <= operand_ptr_in;
        end
    end

    // control word; reserved bits forced to zero so odd writes cannot leak
    assign control_next = do_restore ? (env_control_in & `FPTS_CW_WRITABLE) : control_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) control_reg <= `FPTS_CONTROL_RESET;
        else     control_reg <= control_next;
    end

    assign rounding_select  = fpts_round_t'(control_reg[`FPTS_CW_RND_HI:`FPTS_CW_RND_LO]);
    assign precision_select = fpts_prec_t'(control_reg[`FPTS_CW_PREC_HI:`FPTS_CW_PREC_LO]);
    // mask of the incoming control, so a restore never flashes a stale trap
    assign exc_mask         = control_next[`FPTS_CW_MASK_HI:0];

    // a set mask bit suppresses the trap for that exception
    assign exc_unmasked = exc_next & ~exc_mask;

    // status word next state; hardware raise wins over clear
    assign top_next = do_restore ? env_status_in[`FPTS_SW_TOP_HI:`FPTS_SW_TOP_LO] :
                      stk_push   ? stack_top_index_reg - 3'h1 :
                      stk_pop    ? stack_top_index_reg + 3'h1 :
                                   stack_top_index_reg;

    assign cond_next = do_restore ? {env_status_in[`FPTS_SW_COND3],
                                     env_status_in[`FPTS_SW_COND_HI:`FPTS_SW_COND_LO]} :
                       cond_wr    ? cond_val : cond_reg;

    assign exc_next = (do_restore ? env_status_in[`FPTS_SW_EXC_HI:0] :
                       (clear_exc || fp_init) ? 6'h00 : exc_reg) | exc_raise;

    assign stack_fault_next = (do_restore ? env_status_in[`FPTS_SW_STACK_FAULT] :
                               (clear_exc || fp_init) ? 1'b0 : stack_fault_flag_reg)
                              | stack_fault_raise;

    assign error_summary_next = (|exc_unmasked);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stack_top_index_reg  <= 3'h0;
            cond_reg             <= 4'h0;
            exc_reg              <= 6'h00;
            stack_fault_flag_reg <= 1'b0;
            error_summary_reg    <= 1'b0;
        end else begin
            stack_top_index_reg  <= fp_init ? 3'h0 : top_next;
            cond_reg             <= fp_init ? 4'h0 : cond_next;
            exc_reg              <= exc_next;
            stack_fault_flag_reg <= stack_fault_next;
            error_summary_reg    <= error_summary_next;
        end
    end

    // status assembled combinationally from its fields, no gating on busy
    assign status_next_w = {error_summary_reg,
                            cond_reg[3],
                            stack_top_index_reg,
                            cond_reg[2:0],
                            error_summary_reg,
                            stack_fault_flag_reg,
                            exc_reg};
    assign fpu_status_word = status_next_w;
    assign trap_req        = error_summary_reg;

    // environment store sequencer: streams the image one word a cycle
    always_comb begin
        state_next = state_reg;
        idx_next   = idx_reg;
        case (state_reg)
            FPTS_ST_IDLE: begin
                idx_next = `FPTS_ENV_CONTROL;
                if (start_store) state_next = FPTS_ST_STORE;
            end
            FPTS_ST_STORE: begin
                if (idx_reg == `FPTS_ENV_OP_HI) state_next = FPTS_ST_DONE;
                else idx_next = idx_reg + 3'h1;
            end
            FPTS_ST_DONE: begin
                state_next = FPTS_ST_IDLE;
                idx_next   = `FPTS_ENV_CONTROL;
            end
            default: begin
                state_next = FPTS_ST_IDLE;
                idx_next   = `FPTS_ENV_CONTROL;
            end
        endcase
    end

    // the only path out for the tag word is this image
    always_comb begin
        case (idx_reg)
            `FPTS_ENV_CONTROL: env_word_next = control_reg;
            `FPTS_ENV_STATUS:  env_word_next = status_next_w;
            `FPTS_ENV_TAGS:    env_word_next = fpu_register_tags;
            `FPTS_ENV_IP_LO:   env_word_next = instr_ptr_reg[15:0];
            `FPTS_ENV_IP_HI:   env_word_next = instr_ptr_reg[AW-1:AW-16];
            `FPTS_ENV_OP_LO:   env_word_next = operand_ptr_reg[15:0];
            `FPTS_ENV_OP_HI:   env_word_next = operand_ptr_reg[AW-1:AW-16];
            default:           env_word_next = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg     <= FPTS_ST_IDLE;
            idx_reg       <= 3'h0;
            env_valid_reg <= 1'b0;
            env_word_reg  <= 16'h0000;
            env_index_reg <= 3'h0;
        end else begin
            state_reg     <= state_next;
            idx_reg       <= idx_next;
            env_valid_reg <= (state_reg == FPTS_ST_STORE);
            env_word_reg  <= env_word_next;
            env_index_reg <= idx_reg;
        end
    end

    // sequencer never stalls the integer side; store and restore requests are ignored while busy
    assign env_valid = env_valid_reg;
    assign env_word  = env_word_reg;
    // index registered with its word; the last word keeps its own slot
    assign env_index = env_index_reg;
    assign env_busy  = (state_reg != FPTS_ST_IDLE);
endmodule : fpts_regs

// ### dv/fpts_regs_monitor.sv
module fpts_regs_monitor
    import fpts_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // requests
    input wire logic        fp_init,
    input wire logic        stk_push,
    input wire logic        cond_wr,
    input wire logic [3:0]  cond_val,
    input wire logic [5:0]  exc_raise,
    input wire logic        stack_fault_raise,
    input wire logic        env_store_op,
    input wire logic        full_state_save_op,
    input wire logic        env_restore_op,
    input wire logic [15:0] env_control_in,
    // results
    input wire logic        env_valid,
    input wire logic [2:0]  env_index,
    input wire logic        env_busy,
    input wire logic [15:0] fpu_status_word,
    input wire fpts_round_t rounding_select,
    input wire fpts_prec_t  precision_select
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic [15:0] sw = fpu_status_word;
    wire logic        nrs = !env_restore_op;
    property p_copy; sw[15] == sw[7]; endproperty
    a_copy: assert property (p_copy) else $error("busy copy differs");
    // summary is registered with the flags, so no flags means no summary
    property p_es0; sw[5:0] == 6'h00 |-> !sw[7]; endproperty
    a_es0: assert property (p_es0) else $error("summary without flags");
    property p_exc; exc_raise != 6'h00 && nrs |=> (sw[5:0] & $past(exc_raise)) == $past(exc_raise); endproperty
    a_exc: assert property (p_exc) else $error("flag not recorded");
    property p_sf; stack_fault_raise && nrs |=> sw[6]; endproperty
    a_sf: assert property (p_sf) else $error("stack fault lost");
    property p_init; fp_init && exc_raise == 6'h00 && !stack_fault_raise && nrs |=> (sw[14:0] & 15'h7F7F) == 15'h0000;
    endproperty
    a_init: assert property (p_init) else $error("init left state");
    property p_cond; cond_wr && nrs && !fp_init |=> {sw[14], sw[10:8]} == $past(cond_val); endproperty
    a_cond: assert property (p_cond) else $error("cond code wrong");
    property p_top; stk_push && nrs && !fp_init |=> sw[13:11] == $past(sw[13:11]) - 3'h1; endproperty
    a_top: assert property (p_top) else $error("top not moved");
    property p_store; (env_store_op || full_state_save_op) && !env_busy |=> env_busy ##1 env_valid[*7] ##1 !env_valid;
    endproperty
    a_store: assert property (p_store) else $error("image length wrong");
    property p_idx; env_valid && env_index != 3'h6 |=> env_valid && env_index == $past(env_index) + 3'h1; endproperty
    a_idx: assert property (p_idx) else $error("image order wrong");
    property p_rest; env_restore_op && !env_busy |=> rounding_select == $past(env_control_in[11:10])
        && precision_select == $past(env_control_in[9:8]); endproperty
    a_rest: assert property (p_rest) else $error("mode not restored");
endmodule : fpts_regs_monitor

// ### dv/fpts_core_model.sv
module fpts_core_model
(
    // clock
    input  wire logic        core_clk,
    // capture control
    input  wire logic        cap_clr,
    // image stream
    input  wire logic        env_valid,
    input  wire logic [2:0]  env_index,
    input  wire logic [15:0] env_word,
    // captured image
    output logic [15:0]      img [0:7],
    output logic [3:0]       words
);
    timeunit 1ns;
    timeprecision 1ns;
    // no back-pressure: each word is taken in its single cycle
    always_ff @(posedge core_clk) begin
        if (cap_clr) begin
            words <= 4'h0;
        end else if (env_valid) begin
            img[env_index] <= env_word;
            words          <= words + 4'h1;
        end
    end
endmodule : fpts_core_model

// ### dv/fpts_regs_tb.sv
module fpts_regs_tb
    import fpts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, rst, fp_init, res_wr, stk_push, stk_pop, free_wr, cond_wr, cap_clr;
    logic        stack_fault_raise, clear_exc, ptr_wr, env_store_op, full_state_save_op;
    logic        env_restore_op, env_valid, env_busy, trap_req;
    logic [2:0]  res_phys, free_phys, rd_phys, env_index;
    logic [3:0]  cond_val, words;
    logic [5:0]  exc_raise;
    logic [15:0] env_control_in, env_status_in, env_tags_in, env_word, fpu_status_word;
    logic [15:0] img [0:7];
    logic [79:0] res_data, rd_data;
    logic [31:0] instr_ptr_in, operand_ptr_in;
    fpts_class_t res_class;
    fpts_round_t rounding_select;
    fpts_prec_t  precision_select;
    int          err_total, total_checks;
    fpts_regs i_dut (.*);
    fpts_core_model i_core (.*);
    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic step(input int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic store(input logic full);
        int n;
        n = 0;
        cap_clr = 1'h1;
        step();
        cap_clr = 1'h0;
        full_state_save_op = full;
        env_store_op = !full;
        step();
        full_state_save_op = 1'h0;
        env_store_op = 1'h0;
        while (words !== 4'h7 && n < 40) begin
            step();
            n++;
        end
        chk(16'h0007, {12'h000, words});
        step(3);
    endtask : store
    task automatic restore(input logic [15:0] c, input logic [15:0] t);
        env_control_in = c;
        env_tags_in = t;
        env_restore_op = 1'h1;
        step();
        env_restore_op = 1'h0;
        step();
    endtask : restore
    task automatic t_reset;
        store(1'h0);
        chk(16'h0000, img[0]);
        chk(16'hFFFF, img[2]);
        chk(16'h0000, fpu_status_word);
    endtask : t_reset
    task automatic t_tags;
        logic [15:0] exp;
        exp = 16'hFFFF;
        for (int i = 0; i < 7; i++) begin
            res_wr = 1'h1;
            res_phys = 3'(i);
            res_class = fpts_class_t'(i);
            res_data = {64'h0, 13'h1400, 3'(i)};
            exp[2*i +: 2] = (i < 2) ? 2'(i) : 2'h2;
            step();
        end
        res_wr = 1'h0;
        free_wr = 1'h1;
        free_phys = 3'h5;
        rd_phys = 3'h6;
        ptr_wr = 1'h1;
        instr_ptr_in = 32'h1234_5678;
        operand_ptr_in = 32'h9ABC_DEF0;
        step();
        {free_wr, ptr_wr} = 2'h0;
        chk(16'hA006, rd_data[15:0]);
        exp[11:10] = 2'h3;
        store(1'h1);
        chk(exp, img[2]);
        chk(16'h5678, img[3]);
        chk(16'h9ABC, img[6]);
    endtask : t_tags
    task automatic t_stat;
        cond_wr = 1'h1;
        cond_val = 4'hA;
        stk_push = 1'h1;
        step();
        {cond_wr, stk_push} = 2'h0;
        chk(16'h7A00, fpu_status_word & 16'h7F00);
        stk_pop = 1'h1;
        exc_raise = 6'h21;
        step();
        {stk_pop, exc_raise} = 7'h00;
        chk(16'h0021, fpu_status_word & 16'h383F);
        stack_fault_raise = 1'h1;
        step();
        stack_fault_raise = 1'h0;
        chk(16'h80E1, fpu_status_word & 16'h80FF);
        chk(16'h0001, {15'h0000, trap_req});
        clear_exc = 1'h1;
        exc_raise = 6'h02;
        step();
        {clear_exc, exc_raise} = 7'h00;
        chk(16'h8082, fpu_status_word & 16'h80FF);
        fp_init = 1'h1;
        step();
        fp_init = 1'h0;
        step();
        chk(16'h0000, fpu_status_word);
    endtask : t_stat
    task automatic t_mode;
        logic [1:0] p;
        env_status_in = 16'h3A05;
        restore(16'hFFFF, 16'h0000);
        chk(16'h3A05, fpu_status_word);
        exc_raise = 6'h3F;
        step();
        exc_raise = 6'h00;
        step();
        chk(16'h003F, fpu_status_word & 16'h80FF);
        store(1'h0);
        chk(16'h0F3F, img[0]);
        chk(16'h0000, img[2]);
        for (int i = 0; i < 4; i++) begin
            p = (i == 1) ? 2'h2 : 2'(i);
            restore({4'h0, 2'(i), p, 8'h00}, 16'hFFFF);
            chk({12'h000, 2'(i), p}, {12'h000, rounding_select, precision_select});
        end
    endtask : t_mode
    task automatic t_busy;
        full_state_save_op = 1'h1;
        step();
        full_state_save_op = 1'h0;
        step();
        restore(16'h0000, 16'h0000);
        exc_raise = 6'h04;
        step();
        exc_raise = 6'h00;
        chk(16'h0004, fpu_status_word & 16'h0004);
        step(12);
        chk(16'h000F, {12'h000, rounding_select, precision_select});
    endtask : t_busy
    initial begin
        err_total = 0;
        total_checks = 0;
        rst = 1'h1;
        {fp_init, res_wr, stk_push, stk_pop, free_wr, cond_wr, cap_clr} = 7'h00;
        {stack_fault_raise, clear_exc, ptr_wr, env_store_op, full_state_save_op, env_restore_op} = 6'h00;
        {res_phys, free_phys, rd_phys, cond_val, exc_raise} = 19'h00000;
        {env_control_in, env_status_in, env_tags_in, instr_ptr_in, operand_ptr_in} = 112'h0;
        res_data = 80'h0;
        res_class = FPTS_CLS_NORMAL;
        step(8);
        rst = 1'h0;
        step();
        t_reset();
        t_tags();
        t_stat();
        t_mode();
        t_busy();
        tally_and_finish();
    end
    initial begin
        #160000;
        err_total++;
        tally_and_finish();
    end
endmodule : fpts_regs_tb

bind fpts_regs fpts_regs_monitor i_mon (.*);
